// [src/adc_seq_pkg.sv]
/* Constants and types shared by the converter control block.
   Assumes one 250 MHz system clock and a serial host port. */
package adc_seq_pkg;
   // Control window addresses
   localparam logic [4:0] MODE_ADDR   = 5'h10;
   localparam logic [4:0] MASK_ADDR   = 5'h11;
   localparam logic [4:0] START_ADDR  = 5'h12;
   localparam logic [4:0] STATUS_ADDR = 5'h13;
   // Field positions
   localparam int CTRL_WRITE_BIT = 7;
   localparam int CLK_SRC_BIT    = 5;
   localparam int REF_SEL_BIT    = 4;
   localparam int BYTE_RES_BIT   = 3;
   localparam int IRQ_EN_BIT     = 2;
   localparam int CONV_EN_BIT    = 7;
   localparam int PTR_LOAD_BIT   = 4;
   localparam int HALF_SEL_BIT   = 0;
   // Reset values
   localparam logic [5:0] MODE_RESET = 6'h00;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   // Full scale codes
   localparam logic [9:0] FULL_10 = 10'h3FF;
   localparam logic [9:0] FULL_8  = 10'h0FF;
   // Converter timing
   localparam int CLK_PERIOD_PS = 4000;
   localparam int CONV_CLK_NS   = 500;
   localparam int CONV_DIV      = (CONV_CLK_NS * 1000) / CLK_PERIOD_PS;
   localparam int CONV_TICKS    = 12;
   // Conversion modes
   typedef enum logic [1:0] {
      MODE_IDLE   = 2'b00,
      MODE_SINGLE = 2'b01,
      MODE_SCAN   = 2'b10,
      MODE_CONT   = 2'b11
   } conv_mode_t;
   // Serial access phase
   typedef enum logic [0:0] {
      WAIT_CTRL = 1'b0,
      TRANSFER  = 1'b1
   } access_state_t;
endpackage : adc_seq_pkg

// [src/adc_sequencer_control.sv]
/* Control and status core of an eight channel converter: register
   file reached over the serial port, channel pointer, sequencing and
   flags. Assumes the analog core converts conv_channel on conv_start. */
`timescale 1ns/1ps
//Operation
//RL1 - Mode register at 10h, six bits used
//RL2 - Clock source bit selects pin oscillator
//RL3 - Reference bit enables clipping to full scale
//RL4 - Resolution bit: clear ten bit, set eight
//RL5 - Interrupt pin driven only when enabled
//RL6 - Two bit field picks one of four modes
//RL7 - Pointer steps to next enabled channel, wrapping
//RL8 - Pointer loaded by start write or data address
//RL9 - Mask at 11h; disabled channels skipped
//RL10 - Start register at 12h, field layout
//RL11 - Loaded disabled channel converted only once
//RL12 - Enable starts mode; clearing finishes current
//RL13 - Load bit gates channel number into pointer
//RL14 - Start read returns last written channel
//RL15 - Half bit selects high or low result
//RL16 - Host matches pointer before reading results
//RL17 - Status at 13h stays selected until deselect
//RL18 - Status layout: flags and live pointer
//RL19 - Interrupt flag set and clear events
//RL20 - All done flag set and clear events
//RL21 - Busy drops between scanned channels
//RL22 - Busy cleared by listed register accesses
//RL23 - Reset clears mode register to zero
//RL24 - Control byte: direction bit, five address bits
//RL25 - Control burst increments, stops at status
//RL26 - Continuous mode rescans while enabled
module adc_sequencer_control
   import adc_seq_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       spi_sck,
   input  wire logic       spi_mosi,
   input  wire logic       spi_ce,
   output wire logic       spi_miso,
   output wire logic       spi_miso_oe,
   output var  logic       irq_n,
   output var  logic       irq_n_oe,
   output var  logic       clock_pin_drive,
   output wire logic       clock_source_sel,
   output wire logic       reference_sel,
   output wire logic       byte_resolution_sel,
   output var  logic [9:0] full_scale_code,
   output var  logic       clip_active,
   output var  logic       conv_start,
   output var  logic [2:0] conv_channel
);
   spi_byte_if    sbus ();
   logic [5:0]    mode_select_reg;
   logic [7:0]    channel_enable_mask_reg;
   logic [2:0]    start_chan_reg;
   logic          convert_enable_reg;
   logic          pointer_load_enable_reg;
   logic [2:0]    channel_pointer_reg;
   logic          low_half_reg;
   logic          int_flag_reg;
   logic          all_done_flag_reg;
   logic          busy_converting_reg;
   logic [7:0]    converted_reg;
   logic [7:0]    explicit_reg;
   logic          pend_reg;
   logic          pend_explicit_reg;
   logic          conv_explicit_reg;
   access_state_t acc_state_reg;
   logic [4:0]    addr_reg;
   logic          write_reg;
   logic          tx_oe_reg;
   conv_mode_t    mode;
   logic          ctrl_byte;
   logic          data_byte;
   logic [7:0]    wdata;
   logic          wr_mode;
   logic          wr_mask;
   logic          wr_start;
   logic          data_rd;
   logic          data_done_rd;
   logic          stat_rd;
   logic          clr_all;
   logic          ctrl_is_data;
   logic          issue;
   logic          conv_done;
   logic          conv_active;
   logic [7:0]    cov_now;
   logic          cov_full;
   logic          scan_mode;
   logic          byte_mode;

   // Data register window sits below the control window
   function automatic logic is_data(input logic [4:0] a);
      return !a[4];
   endfunction : is_data

   // Next higher enabled channel, wrapping; stays if none other
   function automatic logic [2:0] next_enabled(input logic [2:0] p,
                                               input logic [7:0] m);
      logic [2:0] c;
      logic [2:0] r;
      logic       hit;
      r   = p;
      hit = 1'b0;
      for (int i = 1; i < 8; i++) begin
         c = p + 3'(i);
         if (!hit && m[c]) begin
            r   = c;
            hit = 1'b1;
         end
      end
      return r;
   endfunction : next_enabled

   spi_byte_port u_port (
      .clk     (clk),
      .resetn  (resetn),
      .sck     (spi_sck),
      .mosi    (spi_mosi),
      .ce      (spi_ce),
      .miso    (spi_miso),
      .miso_oe (spi_miso_oe),
      .bus     (sbus.port)
   );

   sar_timer u_timer (
      .clk    (clk),
      .resetn (resetn),
      .start  (conv_start),
      .abort  (mode == MODE_IDLE),
      .active (conv_active),
      .done   (conv_done)
   );

   // Mode field decode and mode bits driven out
   assign mode      = conv_mode_t'(mode_select_reg[1:0]);  // RL6
   assign scan_mode = mode == MODE_SCAN || mode == MODE_CONT;
   assign byte_mode = mode_select_reg[BYTE_RES_BIT];  // RL4
   assign clock_source_sel    = mode_select_reg[CLK_SRC_BIT];  // RL2
   assign reference_sel       = mode_select_reg[REF_SEL_BIT];
   assign byte_resolution_sel = mode_select_reg[BYTE_RES_BIT];

   // Byte events from the serial port
   assign wdata     = sbus.rx_byte;
   assign ctrl_byte = sbus.byte_valid && acc_state_reg == WAIT_CTRL;
   assign data_byte = sbus.byte_valid && acc_state_reg == TRANSFER;
   assign wr_mode   = data_byte && write_reg && addr_reg == MODE_ADDR;
   assign wr_mask   = data_byte && write_reg && addr_reg == MASK_ADDR;
   assign wr_start  = data_byte && write_reg && addr_reg == START_ADDR;
   assign stat_rd   = data_byte && !write_reg && addr_reg == STATUS_ADDR;
   assign data_rd   = data_byte && !write_reg && is_data(addr_reg);
   assign data_done_rd = data_rd && (byte_mode || addr_reg[0]);
   assign clr_all   = wr_mode || wr_mask || data_rd;
   assign ctrl_is_data = is_data(wdata[4:0]);

   // Coverage of enabled channels including a finishing conversion
   assign cov_now  = converted_reg | (conv_done ? 8'(1 << conv_channel)
                                                : 8'h00);
   assign cov_full = (cov_now & channel_enable_mask_reg)
                     == channel_enable_mask_reg;
   assign issue    = pend_reg && !conv_active && !conv_start
                     && mode != MODE_IDLE;

   // Access phase: control byte first, then data bytes until deselect
   always_ff @(posedge clk) begin
      if (!resetn || sbus.frame_start) begin
         acc_state_reg <= WAIT_CTRL;
         write_reg     <= 1'b0;
         addr_reg      <= 5'h00;
      end else if (ctrl_byte) begin
         acc_state_reg <= TRANSFER;
         write_reg     <= wdata[CTRL_WRITE_BIT];  // RL24
         addr_reg      <= {wdata[4:1], wdata[0] | (ctrl_is_data
                                                   & byte_mode)};
      end else if (data_byte) begin
         if (!is_data(addr_reg)) begin
            if (addr_reg < STATUS_ADDR)
               addr_reg <= addr_reg + 5'h01;  // RL25
         end else if (data_rd) begin
            if (byte_mode || addr_reg[0])
               addr_reg <= {1'b0, next_enabled(channel_pointer_reg,
                            channel_enable_mask_reg), byte_mode};
            else
               addr_reg <= {addr_reg[4:1], 1'b1};
         end
      end
   end

   // Reply drive only while reading after the control byte
   always_ff @(posedge clk) begin
      if (!resetn)
         tx_oe_reg <= 1'b0;
      else
         tx_oe_reg <= acc_state_reg == TRANSFER && !write_reg;
   end
   assign sbus.tx_oe = tx_oe_reg;

   // Read data; result registers and unused addresses read back as zero
   always_comb begin
      case (addr_reg)
         MODE_ADDR:   sbus.tx_byte = {2'b00, mode_select_reg};
         MASK_ADDR:   sbus.tx_byte = channel_enable_mask_reg;
         START_ADDR:  sbus.tx_byte = {convert_enable_reg, 2'b00,
                                      pointer_load_enable_reg,
                                      start_chan_reg,
                                      low_half_reg};  // RL14 RL15
         STATUS_ADDR: sbus.tx_byte = {int_flag_reg, all_done_flag_reg,
                                      busy_converting_reg, 1'b0,
                                      channel_pointer_reg,
                                      1'b0};  // RL17 RL18
         default:     sbus.tx_byte = BYTE_RESET;
      endcase
   end

   // Mode register, cleared at reset; top bits discarded
   always_ff @(posedge clk) begin
      if (!resetn)
         mode_select_reg <= MODE_RESET;  // RL23
      else if (wr_mode)
         mode_select_reg <= wdata[5:0];  // RL1
   end

   // Channel enable mask
   always_ff @(posedge clk) begin
      if (!resetn)
         channel_enable_mask_reg <= BYTE_RESET;
      else if (wr_mask)
         channel_enable_mask_reg <= wdata;  // RL9
   end

   // Start register fields; bits 6 and 5 dropped
   always_ff @(posedge clk) begin
      if (!resetn) begin
         convert_enable_reg      <= 1'b0;
         pointer_load_enable_reg <= 1'b0;
         start_chan_reg          <= 3'h0;
      end else if (wr_start) begin
         convert_enable_reg      <= wdata[CONV_EN_BIT];  // RL10 RL12
         pointer_load_enable_reg <= wdata[PTR_LOAD_BIT];
         start_chan_reg          <= wdata[3:1];  // RL14
      end
   end

   // Channel pointer and next half select
   always_ff @(posedge clk) begin
      if (!resetn) begin
         channel_pointer_reg <= 3'h0;
         low_half_reg        <= 1'b0;
      end else if (wr_start && wdata[PTR_LOAD_BIT]) begin
         channel_pointer_reg <= wdata[3:1];  // RL8 RL13
         low_half_reg <= wdata[HALF_SEL_BIT] | byte_mode;  // RL15
      end else if (ctrl_byte && ctrl_is_data) begin
         channel_pointer_reg <= wdata[3:1];  // RL8
         low_half_reg        <= wdata[0] | byte_mode;
      end else if (data_rd) begin
         if (data_done_rd)
            channel_pointer_reg <= next_enabled(channel_pointer_reg,
                                   channel_enable_mask_reg);  // RL7
         low_half_reg <= byte_mode || !addr_reg[0];
      end else if (conv_done && scan_mode) begin
         channel_pointer_reg <= next_enabled(conv_channel,
                                channel_enable_mask_reg);  // RL7 RL11
      end
   end

   // Pending start: enable write, single mode read, or next scan step
   always_ff @(posedge clk) begin
      if (!resetn) begin
         pend_reg          <= 1'b0;
         pend_explicit_reg <= 1'b0;
      end else if (wr_start && wdata[CONV_EN_BIT]
                   && mode != MODE_IDLE) begin
         pend_reg          <= 1'b1;  // RL12
         pend_explicit_reg <= 1'b1;
      end else if (mode == MODE_IDLE || (wr_start
                   && !wdata[CONV_EN_BIT])) begin
         pend_reg          <= 1'b0;  // RL12
         pend_explicit_reg <= 1'b0;
      end else if (issue) begin
         pend_reg          <= 1'b0;
         pend_explicit_reg <= 1'b0;
      end else if (data_done_rd && mode == MODE_SINGLE
                   && convert_enable_reg) begin
         pend_reg <= 1'b1;
      end else if (conv_done && convert_enable_reg) begin
         if (mode == MODE_CONT)
            pend_reg <= 1'b1;  // RL26
         else if (mode == MODE_SCAN && !cov_full)
            pend_reg <= 1'b1;  // RL21
      end
   end

   // Conversion launch toward the analog core
   always_ff @(posedge clk) begin
      if (!resetn) begin
         conv_start        <= 1'b0;
         conv_channel      <= 3'h0;
         conv_explicit_reg <= 1'b0;
         clip_active       <= 1'b0;
         full_scale_code   <= FULL_10;
      end else begin
         conv_start <= issue;
         full_scale_code <= byte_mode ? FULL_8 : FULL_10;  // RL3
         if (issue) begin
            conv_channel      <= channel_pointer_reg;
            conv_explicit_reg <= pend_explicit_reg;
            clip_active <= reference_sel
                           & channel_enable_mask_reg[channel_pointer_reg];
         end
      end
   end

   // Per channel converted and explicitly started records
   always_ff @(posedge clk) begin
      if (!resetn) begin
         converted_reg <= BYTE_RESET;
         explicit_reg  <= BYTE_RESET;
      end else begin
         for (int i = 0; i < 8; i++) begin
            if (conv_done && conv_channel == 3'(i)) begin
               converted_reg[i] <= 1'b1;
               if (conv_explicit_reg)
                  explicit_reg[i] <= 1'b1;
            end else if (wr_mode || wr_mask || (data_done_rd
                         && addr_reg[3:1] == 3'(i))) begin
               converted_reg[i] <= 1'b0;
               explicit_reg[i]  <= 1'b0;
            end
         end
      end
   end

   // Busy: set at launch, low at each completion and listed accesses
   always_ff @(posedge clk) begin
      if (!resetn)
         busy_converting_reg <= 1'b0;
      else if (issue)
         busy_converting_reg <= 1'b1;  // RL21
      else if (conv_done || mode == MODE_IDLE || clr_all || (wr_start
               && (wdata[CONV_EN_BIT] || wdata[PTR_LOAD_BIT])))
         busy_converting_reg <= 1'b0;  // RL21 RL22
   end

   // Interrupt flag: completions of modes 1 and 2, set beats clear
   always_ff @(posedge clk) begin
      if (!resetn)
         int_flag_reg <= 1'b0;
      else if (conv_done && (mode == MODE_SINGLE
               || (mode == MODE_SCAN && cov_full)))
         int_flag_reg <= 1'b1;  // RL19
      else if (clr_all || stat_rd)
         int_flag_reg <= 1'b0;  // RL19
   end

   // All done flag; single mode needs explicit starts throughout
   always_ff @(posedge clk) begin
      if (!resetn)
         all_done_flag_reg <= 1'b0;
      else if (conv_done && cov_full && (mode != MODE_SINGLE
               || ((explicit_reg | (conv_explicit_reg ? 8'(1 <<
               conv_channel) : 8'h00)) & channel_enable_mask_reg)
               == channel_enable_mask_reg))
         all_done_flag_reg <= 1'b1;  // RL20
      else if (clr_all)
         all_done_flag_reg <= 1'b0;  // RL20
   end

   // Interrupt pin pulls low only when enabled in modes 1 and 2
   always_ff @(posedge clk) begin
      if (!resetn) begin
         irq_n    <= 1'b1;
         irq_n_oe <= 1'b0;
      end else begin
         irq_n    <= 1'b0;
         irq_n_oe <= int_flag_reg && mode_select_reg[IRQ_EN_BIT]
                     && (mode == MODE_SINGLE
                         || mode == MODE_SCAN);  // RL5
      end
   end

   // Internal oscillator runs only for conversions when selected
   always_ff @(posedge clk) begin
      if (!resetn)
         clock_pin_drive <= 1'b0;
      else
         clock_pin_drive <= clock_source_sel && conv_active;  // RL2
   end
endmodule : adc_sequencer_control

// [src/sar_timer.sv]
/* Conversion timer: divides clk into the converter clock and counts
   one conversion. Assumes start only while idle. */
`timescale 1ns/1ps
module sar_timer
   import adc_seq_pkg::*;
(
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic start,
   input  wire logic abort,
   output var  logic active,
   output var  logic done
);
   logic [7:0] div_reg;
   logic [3:0] tick_cnt_reg;
   logic       tick;

   // Converter clock enable, gated off between conversions
   assign tick = active && div_reg == 8'(CONV_DIV - 1);
   always_ff @(posedge clk) begin
      if (!resetn || !active || tick)
         div_reg <= 8'h00;
      else
         div_reg <= div_reg + 8'h01;
   end

   // Conversion length in converter clocks
   always_ff @(posedge clk) begin
      if (!resetn || abort) begin
         active       <= 1'b0;
         done         <= 1'b0;
         tick_cnt_reg <= 4'h0;
      end else begin
         done <= 1'b0;
         if (start) begin
            active       <= 1'b1;
            tick_cnt_reg <= 4'h0;
         end else if (tick) begin
            if (tick_cnt_reg == 4'(CONV_TICKS - 1)) begin
               active <= 1'b0;
               done   <= 1'b1;
            end else begin
               tick_cnt_reg <= tick_cnt_reg + 4'h1;
            end
         end
      end
   end
endmodule : sar_timer

// [src/spi_byte_if.sv]
/* Byte channel between the serial pin port and the register core.
   Assumes both ends run on the same system clock. */
`timescale 1ns/1ps
interface spi_byte_if;
   logic       frame_start;
   logic       byte_valid;
   logic [7:0] rx_byte;
   logic [7:0] tx_byte;
   logic       tx_oe;
   modport port (output frame_start, byte_valid, rx_byte,
                 input  tx_byte, tx_oe);
   modport core (input  frame_start, byte_valid, rx_byte,
                 output tx_byte, tx_oe);
endinterface : spi_byte_if

// [src/spi_byte_port.sv]
/* Serial slave pin port: samples the host pins, finds clock edges,
   assembles bytes and shifts reply bytes out.
   Assumes pins are asynchronous to clk and slow against it. */
`timescale 1ns/1ps
module spi_byte_port
   import adc_seq_pkg::*;
(
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic sck,
   input  wire logic mosi,
   input  wire logic ce,
   output var  logic miso,
   output var  logic miso_oe,
   spi_byte_if.port  bus
);
   logic [2:0] sync1_reg;
   logic [2:0] sync2_reg;
   logic [2:0] sync3_reg;
   logic [2:0] level_reg;
   logic [2:0] prev_reg;
   logic       pol_reg;
   logic [2:0] bit_cnt_reg;
   logic [7:0] rx_sr_reg;
   logic [6:0] tx_sr_reg;
   logic       ce_rise;
   logic       rise;
   logic       fall;
   logic       out_edge;
   logic       samp_edge;

   // Three stage sampling; level moves once stages two and three agree
   always_ff @(posedge clk) begin
      if (!resetn) begin
         sync1_reg <= 3'h0;
         sync2_reg <= 3'h0;
         sync3_reg <= 3'h0;
         level_reg <= 3'h0;
         prev_reg  <= 3'h0;
      end else begin
         sync1_reg <= {ce, mosi, sck};
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         level_reg <= (~(sync2_reg ^ sync3_reg) & sync3_reg)
                    | ((sync2_reg ^ sync3_reg) & level_reg);
         prev_reg  <= level_reg;
      end
   end

   // Edge decode; leading edge shifts out, trailing edge samples
   assign ce_rise   = level_reg[2] & ~prev_reg[2];
   assign rise      = level_reg[0] & ~prev_reg[0];
   assign fall      = ~level_reg[0] & prev_reg[0];
   assign out_edge  = level_reg[2] & ~ce_rise & (pol_reg ? fall : rise);
   assign samp_edge = level_reg[2] & ~ce_rise & (pol_reg ? rise : fall);

   // Idle clock level caught at select
   always_ff @(posedge clk) begin
      if (!resetn)
         pol_reg <= 1'b0;
      else if (ce_rise)
         pol_reg <= level_reg[0];
   end

   // Receive shifter and byte strobe
   always_ff @(posedge clk) begin
      if (!resetn) begin
         bit_cnt_reg     <= 3'h0;
         rx_sr_reg       <= BYTE_RESET;
         bus.rx_byte     <= BYTE_RESET;
         bus.byte_valid  <= 1'b0;
         bus.frame_start <= 1'b0;
      end else begin
         bus.frame_start <= ce_rise;
         bus.byte_valid  <= samp_edge && bit_cnt_reg == 3'h7;
         if (ce_rise || !level_reg[2]) begin
            bit_cnt_reg <= 3'h0;
         end else if (samp_edge) begin
            rx_sr_reg   <= {rx_sr_reg[6:0], level_reg[1]};
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7)
               bus.rx_byte <= {rx_sr_reg[6:0], level_reg[1]};
         end
      end
   end

   // Transmit shifter, reply loaded at each byte start
   always_ff @(posedge clk) begin
      if (!resetn) begin
         tx_sr_reg <= 7'h00;
         miso      <= 1'b0;
         miso_oe   <= 1'b0;
      end else begin
         miso_oe <= level_reg[2] & bus.tx_oe;
         if (out_edge) begin
            if (bit_cnt_reg == 3'h0) begin
               miso      <= bus.tx_byte[7];
               tx_sr_reg <= bus.tx_byte[6:0];
            end else begin
               miso      <= tx_sr_reg[6];
               tx_sr_reg <= {tx_sr_reg[5:0], 1'b0};
            end
         end
      end
   end
endmodule : spi_byte_port

// [test/adc_sequencer_control_bench.sv]
/* Self-checking bench for the converter control block.
   Assumes the host model drives the serial pins. */
`timescale 1ns/1ps
module adc_sequencer_control_bench;
   import adc_seq_pkg::*;
   typedef struct {logic [4:0] a; logic [7:0] d; logic [7:0] e;} row_t;
   logic       clk, resetn, miso_w;
   wire logic  sck, mosi, ce, miso, oe, irq_n, irq_oe, drv, cs, rs, bs, cst;
   wire logic [9:0] fsc;
   wire logic [2:0] ch;
   logic [15:0] rx;
   logic [2:0]  seen_q [$];
   int          errors, cmp_count, cycles, n;
   // Write, then read back
   row_t rows [5] = '{'{MODE_ADDR, 8'hFF, 8'h3F}, '{MASK_ADDR, 8'hA5, 8'hA5},
      '{START_ADDR, 8'h1E, 8'h1F}, '{STATUS_ADDR, 8'hFF, 8'h0E},
      '{5'h14, 8'h5A, 8'h00}};
   assign miso_w = oe ? miso : ~miso;
   host_model u_host (.sck(sck), .mosi(mosi), .ce(ce), .miso(miso_w));
   adc_sequencer_control u_adc_sequencer_control (.clk(clk),
      .resetn(resetn), .spi_sck(sck), .spi_mosi(mosi), .spi_ce(ce),
      .spi_miso(miso), .spi_miso_oe(oe), .irq_n(irq_n), .irq_n_oe(irq_oe),
      .clock_pin_drive(drv), .clock_source_sel(cs), .reference_sel(rs),
      .byte_resolution_sel(bs), .full_scale_code(fsc), .clip_active(),
      .conv_start(cst), .conv_channel(ch));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      u_host.frame({3'b100, a}, d, 1, rx);
   endtask : wr
   task automatic rd(input logic [4:0] a, input int k);
      u_host.frame({3'b000, a}, 8'h00, k, rx);
   endtask : rd
   task automatic wait_start(input logic [2:0] c);
      for (int k = 0; k < 4000 && seen_q.size() == 0; k++) @(posedge clk);
      check(seen_q.size() ? seen_q.pop_front() : 3'bxxx, c);
   endtask : wait_start
   task automatic complete_run();
      $display("errors=%0d cmp_count=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : complete_run
   // Clock and launch log with hang limit
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cst === 1'b1) seen_q.push_back(ch);
      if (cycles == 70000) begin
         errors++;
         complete_run();
      end
   end
   // Main sequence
   initial begin
      resetn = 1'b0;
      repeat (4) @(posedge clk);
      #1 resetn = 1'b1;
      repeat (20) @(posedge clk);
      rd(MODE_ADDR, 1);
      check(rx[7:0], 8'h00);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, 1);
         check(rx[7:0], rows[i].e);
      end
      check({cs, rs, bs, fsc}, {3'b111, FULL_8});
      wr(MODE_ADDR, 8'h05);
      wr(MASK_ADDR, 8'h01);
      wr(START_ADDR, 8'h96);
      wait_start(3'd3);
      for (n = 0; n < 3000 && irq_oe !== 1'b1; n++) @(posedge clk);
      check(irq_oe, 1'b1);
      rd(STATUS_ADDR, 2);
      check(rx, 16'h8606);
      check(irq_oe, 1'b0);
      wr(START_ADDR, 8'h00);
      wr(MASK_ADDR, 8'h06);
      wr(MODE_ADDR, 8'h12);
      wr(START_ADDR, 8'h94);
      wait_start(3'd2);
      wait_start(3'd1);
      repeat (1600) @(posedge clk);
      check({seen_q.size() == 0, irq_oe}, 2'b10);
      rd(STATUS_ADDR, 1);
      check(rx[7:0], 8'hC4);
      wr(START_ADDR, 8'h00);
      wr(MODE_ADDR, 8'h23);
      wr(START_ADDR, 8'h94);
      wait_start(3'd2);
      wait_start(3'd1);
      wait_start(3'd2);
      wr(START_ADDR, 8'h00);
      n = seen_q.size();
      repeat (2000) @(posedge clk);
      check(seen_q.size(), n);
      complete_run();
   end
endmodule : adc_sequencer_control_bench

// [test/adc_sequencer_control_checker.sv]
/* Port checker for the converter control block.
   Assumes it is bound into adc_sequencer_control. */
`timescale 1ns/1ps
module adc_sequencer_control_checker
   import adc_seq_pkg::*;
(
   input wire logic       clk,
   input wire logic       resetn,
   input wire logic       spi_ce,
   input wire logic       spi_miso_oe,
   input wire logic       irq_n,
   input wire logic       irq_n_oe,
   input wire logic       clock_pin_drive,
   input wire logic       clock_source_sel,
   input wire logic       byte_resolution_sel,
   input wire logic [9:0] full_scale_code,
   input wire logic       clip_active,
   input wire logic       conv_start,
   input wire logic [2:0] conv_channel
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // Launch pulse followed by a steady channel
   sequence launch_s;
      conv_start ##1 !conv_start;
   endsequence
   irq_pin_a: assert property (irq_n_oe |-> !irq_n)
      else $error("irq pin enabled while high");
   scale_track_a: assert property (full_scale_code ==
      ($past(byte_resolution_sel) ? FULL_8 : FULL_10))
      else $error("full scale code wrong");
   start_pulse_a: assert property (conv_start |=> !conv_start)
      else $error("launch longer than one cycle");
   osc_drive_a: assert property (clock_pin_drive |->
      $past(clock_source_sel))
      else $error("oscillator driven with external source");
   miso_off_a: assert property ($fell(spi_ce) |-> ##[1:8] !spi_miso_oe)
      else $error("reply driven after deselect");
   chan_hold_a: assert property (launch_s |-> ##1
      $stable(conv_channel)[*8])
      else $error("channel moved during conversion");
   clip_launch_a: assert property ($rose(clip_active) |-> conv_start)
      else $error("clipping latched outside launch");
   reset_state_a: assert property ($rose(resetn) |-> irq_n &&
      !irq_n_oe && !conv_start && full_scale_code == FULL_10)
      else $error("outputs not at reset state");
endmodule : adc_sequencer_control_checker
bind adc_sequencer_control adc_sequencer_control_checker u_chk (
   .clk(clk), .resetn(resetn), .spi_ce(spi_ce), .irq_n(irq_n),
   .spi_miso_oe(spi_miso_oe), .irq_n_oe(irq_n_oe),
   .clock_pin_drive(clock_pin_drive), .clip_active(clip_active),
   .clock_source_sel(clock_source_sel), .conv_start(conv_start),
   .byte_resolution_sel(byte_resolution_sel),
   .full_scale_code(full_scale_code), .conv_channel(conv_channel));

// [test/host_model.sv]
/* Serial host model driving chip enable, clock and data in.
   Assumes the bench calls frame and feeds back the resolved reply. */
`timescale 1ns/1ps
module host_model (
   output var  logic sck,
   output var  logic mosi,
   output var  logic ce,
   input  wire logic miso
);
   // Pins idle with the clock low
   initial begin
      sck = 1'b0;
      mosi = 1'b0;
      ce = 1'b0;
   end
   // One byte, MSB first, 160 ns clock
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         #40 mosi = tx[i]; // Data moves mid low phase, clear of sample edge
         #40 sck = 1'b1;
         #70 rx[i] = miso;
         #10 sck = 1'b0;
      end
      #40 mosi = ~mosi; // Released line shows no stale bit
   endtask : xfer
   // Control byte, then n bytes of d; last two replies kept
   task automatic frame(input logic [7:0] c, input logic [7:0] d,
                        input int n, output logic [15:0] rx);
      logic [7:0] b;
      rx = '0;
      ce = 1'b1;
      #200 xfer(c, b);
      for (int i = 0; i < n; i++) begin
         xfer(d, b);
         rx = {rx[7:0], b};
      end
      #200 ce = 1'b0;
      #200;
   endtask : frame
endmodule : host_model
